//--- core/sss_top.sv
// Safe stop sequencer for one servo axis with an Avalon-MM register slave.
//
// Contract
// - Stop one trigger starts timer, then torque off.
// - Stop one status set until torque removal.
// - Manual restart holds torque off until acknowledge.
// - Leaving window restarts dwell timing.
// - Ramp check waits for monitoring delay.
// - Ramp limit falls one step per millisecond.
// - Ramp seeded with speed at trigger.
// - Ramp reaching window ends stop one.
// - Torque off no later than delay, unless an early ending's brake lead runs past it.
// - Dwell and ramp endings work together.
// - Speed above ramp limit forces torque off.
// - Brake at delay minus closing time.
// - Dwell ending: brake first, torque later.
// - Ramp ending: brake first, torque later.
// - Closing time comes from chosen brake.
// - A chosen brake leads torque removal, except on ramp overrun.
// - Window checked when delay expires.
// - Either error forces immediate torque off.
// - Zero window limit zero disables check.
// - Zero dwell time zero disables dwell early end.
// - Brake select: none or one of eight.
// - Stop one status held during brake lead.
// - Stop two ends in standstill hold.
// - Standstill hold after hold delay.
// - Stop two completes after short trigger.
// - Stop two restart automatic or manual.
`include "sss_consts.svh"
module sss_top
  import sss_pkg::*;
#(
  parameter int NUM_BRAKES = 8
)(
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Avalon-MM register slave.
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Safety controller commands.
  input  wire logic                  stop_one_trig,
  input  wire logic                  stop_two_trig,
  input  wire logic                  restart_ack,
  // Drive speed sample and time base.
  input  wire logic [`SSS_SPD_W-1:0] speed_in,
  input  wire logic                  cycle_tick,
  input  wire logic                  ms_tick,
  // Sequencer status to the drive and controller.
  output logic                       torque_off,
  output logic                       stop_one_active,
  output logic                       brake_cmd,
  output logic      [`SSS_SEL_W-1:0] brake_inst,
  output logic                       stop_two_active,
  output logic                       hold_active,
  output logic                       ack_request
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************

  // The selector field must address every brake instance.
  if (NUM_BRAKES < 1 || NUM_BRAKES >= (1 << `SSS_SEL_W))
  begin : g_chk
    $error("NUM_BRAKES out of range");
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************

  sss_cfg_t              cfg_q, cfg_d;       // Configuration registers.
  logic [`SSS_SPD_W-1:0] lim_q, lim_d;       // Ramp speed limit.
  logic [`SSS_TMR_W-1:0] bt_q [NUM_BRAKES];  // Brake closing times.
  logic                  ack_q, ack_d;       // Access answer phase.
  logic [31:0]           rd_q, rd_d;         // Registered read data.
  logic [31:0]           wmask;              // Byte lanes of a write.
  logic [31:0]           status;             // Live status word.
  logic                  wr_go;              // A write takes effect.

  // Reads and writes each take one wait cycle so data comes from flops.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rd_q;
  assign wr_go           = avs_write & ~ack_q;

  // Expand byte enables into a bit mask.
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  // Merge the written low lanes over an old 16-bit value.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m[15:0]) | (wd[15:0] & m[15:0]);
  endfunction : merge

  // Next values of the configuration and the read path.
  always_comb
  begin
    cfg_d = cfg_q;
    ack_d = (avs_read | avs_write) & ~ack_q;
    rd_d  = rd_q;
    if (wr_go)
    begin
      case (avs_address)
        `SSS_OFS_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            cfg_d.decel_en = avs_writedata[`SSS_CTRL_DECEL];
            cfg_d.man_one  = avs_writedata[`SSS_CTRL_MAN1];
            cfg_d.man_two  = avs_writedata[`SSS_CTRL_MAN2];
          end
        end
        `SSS_OFS_TOFF:
          cfg_d.toff_dly = merge(cfg_q.toff_dly, avs_writedata, wmask);
        `SSS_OFS_ZLIM:
          cfg_d.zero_lim = merge(cfg_q.zero_lim, avs_writedata, wmask);
        `SSS_OFS_ZDWELL:
          cfg_d.zero_dwell = merge(cfg_q.zero_dwell, avs_writedata, wmask);
        `SSS_OFS_DDELAY:
          cfg_d.decel_dly = merge(cfg_q.decel_dly, avs_writedata, wmask);
        `SSS_OFS_DSTEP:
          cfg_d.decel_step = merge(cfg_q.decel_step, avs_writedata, wmask);
        `SSS_OFS_BSEL:
          // Selections above the last instance mean no brake.
          cfg_d.brake_sel = avs_byteenable[0] ? avs_writedata[3:0] :
                                                cfg_q.brake_sel;
        `SSS_OFS_HOLD:
          cfg_d.hold_dly = merge(cfg_q.hold_dly, avs_writedata, wmask);
        default:
          cfg_d = cfg_q;
      endcase
    end
    if (avs_read & ~ack_q)
    begin
      rd_d = 32'h0;
      case (avs_address)
        `SSS_OFS_CTRL:   rd_d = {29'h0, cfg_q.man_two, cfg_q.man_one,
                                 cfg_q.decel_en};
        `SSS_OFS_TOFF:   rd_d = {16'h0, cfg_q.toff_dly};
        `SSS_OFS_ZLIM:   rd_d = {16'h0, cfg_q.zero_lim};
        `SSS_OFS_ZDWELL: rd_d = {16'h0, cfg_q.zero_dwell};
        `SSS_OFS_DDELAY: rd_d = {16'h0, cfg_q.decel_dly};
        `SSS_OFS_DSTEP:  rd_d = {16'h0, cfg_q.decel_step};
        `SSS_OFS_BSEL:   rd_d = {28'h0, cfg_q.brake_sel};
        `SSS_OFS_HOLD:   rd_d = {16'h0, cfg_q.hold_dly};
        `SSS_OFS_STAT:   rd_d = status;
        `SSS_OFS_LIMIT:  rd_d = {16'h0, lim_q};
        default:
        begin
          // Brake closing times follow the base, unmapped words read zero.
          for (int i = 0; i < NUM_BRAKES; i++)
          begin
            if (avs_address == 8'(`SSS_OFS_BTIME + 4*i))
            begin
              rd_d = {16'h0, bt_q[i]};
            end
          end
        end
      endcase
    end
  end

  // Register the configuration and the read path.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q          <= '0;
      cfg_q.toff_dly <= `SSS_RST_TOFF;
      cfg_q.hold_dly <= `SSS_RST_HOLD;
      ack_q          <= 1'b0;
      rd_q           <= 32'h0;
    end
    else
    begin
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end

  // One closing-time register per brake instance.
  for (genvar g = 0; g < NUM_BRAKES; g++)
  begin : g_bt
    logic [`SSS_TMR_W-1:0] bt_d;  // Next closing time.
    always_comb
    begin
      bt_d = bt_q[g];
      if (wr_go && avs_address == 8'(`SSS_OFS_BTIME + 4*g))
      begin
        bt_d = merge(bt_q[g], avs_writedata, wmask);
      end
    end
    always_ff @(posedge core_clk or negedge rstn)
    begin
      if (!rstn)
        bt_q[g] <= `SSS_RST_ZERO;
      else
        bt_q[g] <= bt_d;
    end
  end

  // ****************************************************************
  // Speed evaluation
  // ****************************************************************

  logic [`SSS_SPD_W-1:0] mag;           // Speed magnitude.
  logic                  in_win;        // Speed inside zero window.
  logic                  brk_en;        // A brake instance is chosen.
  logic [`SSS_TMR_W-1:0] tb;            // Chosen brake closing time.

  // Magnitude saturates so the most negative code is not read as small.
  always_comb
  begin
    if (!speed_in[`SSS_SPD_W-1])
      mag = speed_in;
    else if (speed_in == {1'b1, {(`SSS_SPD_W-1){1'b0}}})
      mag = {1'b0, {(`SSS_SPD_W-1){1'b1}}};
    else
      mag = -speed_in;
    in_win = (mag <= cfg_q.zero_lim);
    brk_en = (cfg_q.brake_sel != '0) &&
             (cfg_q.brake_sel <= `SSS_SEL_W'(NUM_BRAKES));
    tb     = '0;
    for (int i = 0; i < NUM_BRAKES; i++)
    begin
      if (cfg_q.brake_sel == `SSS_SEL_W'(i + 1))
        tb = bt_q[i];
    end
  end

  // ****************************************************************
  // Stop sequences
  // ****************************************************************

  sss_s1_t               s1_q, s1_d;     // Stop type one state.
  sss_s2_t               s2_q, s2_d;     // Stop type two state.
  logic [`SSS_TMR_W-1:0] el_q, el_d;     // Ticks since stop one trigger.
  logic [`SSS_TMR_W-1:0] dw_q, dw_d;     // Ticks inside zero window.
  logic [`SSS_TMR_W-1:0] bl_q, bl_d;     // Ticks of brake lead.
  logic [`SSS_TMR_W-1:0] c2_q, c2_d;     // Ticks since stop two trigger.
  logic                  brk_q, brk_d;   // Brake command.
  logic                  zerr_q, zerr_d; // Zero window error flag.
  logic                  rerr_q, rerr_d; // Ramp overrun error flag.
  logic                  ak1_q, ak1_d;   // Acknowledge wanted, stop one.
  logic                  ak2_q, ak2_d;   // Acknowledge wanted, stop two.
  logic                  rprev_q;        // Previous acknowledge level.
  logic                  ack_rise;       // Acknowledge rising edge.
  logic [`SSS_TMR_W-1:0] el_n;           // Elapsed count after a tick.
  logic                  mon;            // Ramp monitoring running.
  logic                  early;          // Dwell or ramp has finished.

  assign ack_rise = restart_ack & ~rprev_q;
  assign el_n     = el_q + `SSS_TMR_W'(1);
  assign mon      = cfg_q.decel_en && (el_q >= cfg_q.decel_dly);
  // Either early ending finishes the stop, whichever comes first.
  assign early    = ((cfg_q.zero_dwell != '0) &&
                     (dw_q >= cfg_q.zero_dwell)) ||
                    (mon && (lim_q <= cfg_q.zero_lim));

  // Next state of both sequences; timers step on cycle_tick, the ramp limit on ms_tick.
  always_comb
  begin
    s1_d   = s1_q;
    s2_d   = s2_q;
    el_d   = el_q;
    dw_d   = dw_q;
    bl_d   = bl_q;
    c2_d   = c2_q;
    lim_d  = lim_q;
    brk_d  = brk_q;
    zerr_d = zerr_q;
    rerr_d = rerr_q;
    ak1_d  = ak1_q;
    ak2_d  = ak2_q;
    case (s1_q)
      S1_IDLE:
        if (stop_one_trig)
        begin
          s1_d   = S1_RUN;
          el_d   = '0;
          dw_d   = '0;
          bl_d   = '0;
          lim_d  = mag;
          zerr_d = 1'b0;
          rerr_d = 1'b0;
        end
      S1_RUN:
      begin
        // Ramp limit drops per millisecond, never below the window.
        if (ms_tick && mon)
        begin
          if (lim_q > cfg_q.zero_lim &&
              (lim_q - cfg_q.zero_lim) > cfg_q.decel_step)
            lim_d = lim_q - cfg_q.decel_step;
          else
            lim_d = cfg_q.zero_lim;
        end
        if (cycle_tick)
        begin
          el_d = el_n;
          // Leaving the window drops the dwell measured so far.
          dw_d = !in_win ? '0 : (dw_q == '1) ? dw_q : dw_q + 1'b1;
          // Brake leads the delay expiry by its closing time.
          if (brk_en && (tb >= cfg_q.toff_dly ||
                         el_n >= cfg_q.toff_dly - tb))
            brk_d = 1'b1;
          if (mon && mag > lim_q)
          begin
            rerr_d = 1'b1;
            s1_d   = S1_OFF;
          end
          else if (el_n >= cfg_q.toff_dly)
          begin
            // A zero limit of zero turns the end check off.
            if (cfg_q.zero_lim != '0 && !in_win)
              zerr_d = 1'b1;
            s1_d = S1_OFF;
          end
          else if (early && brk_en)
          begin
            brk_d = 1'b1;
            bl_d  = '0;
            s1_d  = S1_LEAD;
          end
          else if (early)
            s1_d = S1_OFF;
        end
      end
      S1_LEAD:
        // Status stays on until the brake has had its closing time.
        if (cycle_tick)
        begin
          bl_d = bl_q + 1'b1;
          if (bl_q + 1'b1 >= tb)
            s1_d = S1_OFF;
        end
      S1_OFF:
      begin
        ak1_d = cfg_q.man_one;
        // Torque stays off while triggered or waiting for acknowledge.
        if (!stop_one_trig && (!cfg_q.man_one || ack_rise))
        begin
          s1_d  = S1_IDLE;
          brk_d = 1'b0;
          ak1_d = 1'b0;
        end
      end
      default:
        s1_d = S1_IDLE;
    endcase
    case (s2_q)
      S2_IDLE:
        // The trigger is latched, so a short pulse still completes.
        if (stop_two_trig)
        begin
          s2_d = S2_RUN;
          c2_d = '0;
        end
      S2_RUN:
        if (cycle_tick)
        begin
          c2_d = c2_q + 1'b1;
          if (c2_q + 1'b1 >= cfg_q.hold_dly)
            s2_d = S2_HOLD;
        end
      S2_HOLD:
      begin
        ak2_d = cfg_q.man_two;
        if (!stop_two_trig && (!cfg_q.man_two || ack_rise))
        begin
          s2_d  = S2_IDLE;
          ak2_d = 1'b0;
        end
      end
      default:
        s2_d = S2_IDLE;
    endcase
  end

  // Register both sequences.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q    <= S1_IDLE;
      s2_q    <= S2_IDLE;
      el_q    <= '0;
      dw_q    <= '0;
      bl_q    <= '0;
      c2_q    <= '0;
      lim_q   <= '0;
      brk_q   <= 1'b0;
      zerr_q  <= 1'b0;
      rerr_q  <= 1'b0;
      ak1_q   <= 1'b0;
      ak2_q   <= 1'b0;
      rprev_q <= 1'b0;
    end
    else
    begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      el_q    <= el_d;
      dw_q    <= dw_d;
      bl_q    <= bl_d;
      c2_q    <= c2_d;
      lim_q   <= lim_d;
      brk_q   <= brk_d;
      zerr_q  <= zerr_d;
      rerr_q  <= rerr_d;
      ak1_q   <= ak1_d;
      ak2_q   <= ak2_d;
      rprev_q <= restart_ack;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Status decodes straight from state flops.
  assign stop_one_active = (s1_q == S1_RUN) || (s1_q == S1_LEAD);
  assign torque_off      = (s1_q == S1_OFF);
  assign brake_cmd       = brk_q;
  assign brake_inst      = cfg_q.brake_sel;
  assign stop_two_active = (s2_q == S2_RUN);
  assign hold_active     = (s2_q == S2_HOLD);
  assign ack_request     = ak1_q | ak2_q;
  assign status          = {23'h0, ak2_q, hold_active, stop_two_active,
                            rerr_q, zerr_q, ak1_q, brk_q, torque_off,
                            stop_one_active};

endmodule : sss_top

//--- core/sss_consts.svh
// Offsets, field positions, reset values and widths of the safe stop sequencer.
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// Data widths of speed samples, tick timers and the brake selector.
`define SSS_SPD_W        16
`define SSS_TMR_W        16
`define SSS_SEL_W        4

// Register byte offsets on the Avalon-MM slave.
`define SSS_OFS_CTRL     8'h00
`define SSS_OFS_TOFF     8'h04
`define SSS_OFS_ZLIM     8'h08
`define SSS_OFS_ZDWELL   8'h0c
`define SSS_OFS_DDELAY   8'h10
`define SSS_OFS_DSTEP    8'h14
`define SSS_OFS_BSEL     8'h18
`define SSS_OFS_HOLD     8'h1c
`define SSS_OFS_STAT     8'h20
`define SSS_OFS_LIMIT    8'h24
`define SSS_OFS_BTIME    8'h40

// Control register bit positions.
`define SSS_CTRL_DECEL   0
`define SSS_CTRL_MAN1    1
`define SSS_CTRL_MAN2    2

// Reset values of the configuration registers.
`define SSS_RST_TOFF     16'h0064
`define SSS_RST_HOLD     16'h0064
`define SSS_RST_ZERO     16'h0000

`endif

//--- core/sss_pkg.sv
// Types shared by the safe stop sequencer.
`include "sss_consts.svh"
package sss_pkg;

  // Software settings of both stop sequences.
  typedef struct packed {
    logic                  decel_en;
    logic                  man_one;
    logic                  man_two;
    logic [`SSS_TMR_W-1:0] toff_dly;
    logic [`SSS_SPD_W-1:0] zero_lim;
    logic [`SSS_TMR_W-1:0] zero_dwell;
    logic [`SSS_TMR_W-1:0] decel_dly;
    logic [`SSS_SPD_W-1:0] decel_step;
    logic [`SSS_SEL_W-1:0] brake_sel;
    logic [`SSS_TMR_W-1:0] hold_dly;
  } sss_cfg_t;

  // Stop type one sequence states.
  typedef enum logic [1:0] {S1_IDLE, S1_RUN, S1_LEAD, S1_OFF} sss_s1_t;

  // Stop type two sequence states.
  typedef enum logic [1:0] {S2_IDLE, S2_RUN, S2_HOLD} sss_s2_t;

endpackage : sss_pkg

//--- sim/sss_checker.sv
// Port-level assertions and covers for the safe stop sequencer.
module sss_checker
#(
  parameter int NUM_BRAKES = 8
)(
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       rstn,
  // Register bus handshake.
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // Commands and time base.
  input wire logic       stop_one_trig,
  input wire logic       cycle_tick,
  // Sequencer outputs.
  input wire logic       torque_off,
  input wire logic       stop_one_active,
  input wire logic       brake_cmd,
  input wire logic [3:0] brake_inst,
  input wire logic       stop_two_active,
  input wire logic       hold_active,
  input wire logic       ack_request
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // Properties
  // ********
  // One clock domain.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // A bus request waits exactly one cycle.
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  // Status and torque off never overlap.
  property p_excl;
    !(torque_off && stop_one_active);
  endproperty
  // Idle takes the trigger at once.
  property p_take;
    stop_one_trig && !stop_one_active && !torque_off |=> stop_one_active || torque_off;
  endproperty
  // Torque off follows a timer step.
  property p_tick;
    $rose(torque_off) |-> $past(cycle_tick);
  endproperty
  // Leaving stop one means torque off.
  property p_fall;
    $fell(stop_one_active) |-> torque_off;
  endproperty
  // Hold only out of stop two.
  property p_hold;
    $rose(hold_active) |-> $past(stop_two_active);
  endproperty
  // Acknowledge wanted only while a stop holds.
  property p_ack;
    ack_request |-> torque_off || hold_active;
  endproperty
  // No brake selected, no brake.
  property p_nobrake;
    brake_inst == 4'h0 |-> !brake_cmd;
  endproperty

  a_one_wait: assert property (p_one_wait) else $error("bus wait");
  a_excl: assert property (p_excl) else $error("overlap");
  a_take: assert property (p_take) else $error("no take");
  a_tick: assert property (p_tick) else $error("no tick");
  a_fall: assert property (p_fall) else $error("bad fall");
  a_hold: assert property (p_hold) else $error("bad hold");
  a_ack: assert property (p_ack) else $error("stray ack");
  a_nobrake: assert property (p_nobrake) else $error("stray brake");

  // Main scenarios reached.
  c_off: cover property ($rose(torque_off));
  c_brake: cover property ($rose(brake_cmd));
  c_hold: cover property ($rose(hold_active));
endmodule : sss_checker

//--- sim/sss_ctrl_model.sv
// Behavioural safety controller that issues the stop control bits.
module sss_ctrl_model
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Orders from the bench.
  input  wire logic        go_one,
  input  wire logic        go_two,
  input  wire logic        go_ack,
  input  wire logic [15:0] go_len,
  // Control bits to the sequencer.
  output logic             stop_one_trig,
  output logic             stop_two_trig,
  output logic             restart_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] cnt_q;  // Cycles the raised bit still stands.

  // ********
  // Command logic
  // ********
  // A control bit stands go_len plus one cycles.
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q         <= 16'h0000;
      stop_one_trig <= 1'b0;
      stop_two_trig <= 1'b0;
      restart_ack   <= 1'b0;
    end
    else
    begin
      if (go_one || go_two)
      begin
        cnt_q         <= go_len;
        stop_one_trig <= go_one;
        stop_two_trig <= go_two;
      end
      else if (cnt_q != 16'h0000)
        cnt_q <= cnt_q - 16'h0001;
      else
      begin
        stop_one_trig <= 1'b0;
        stop_two_trig <= 1'b0;
      end
      // One high cycle after a low one gives a clean rising edge.
      restart_ack <= go_ack;
    end
  end
endmodule : sss_ctrl_model

//--- sim/test_safe_stop_sequencer.sv
// Self-checking bench of the safe stop sequencer.
`include "sss_consts.svh"
module test_safe_stop_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // Signals
  // ********
  logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rnd_q;
  logic [3:0]  avs_byteenable, brake_inst, tdiv;
  logic        stop_one_trig, stop_two_trig, restart_ack, cycle_tick, ms_tick;
  logic [15:0] speed_in, spd_fix, go_len;
  logic        torque_off, stop_one_active, brake_cmd, stop_two_active;
  logic        hold_active, ack_request, go_one, go_two, go_ack, rnd_en;
  int          error_cnt, compares, cyc;

  sss_top        i_dut (.*);
  sss_ctrl_model i_ctrl (.*);

  // ********
  // Clock, time base, speed and timeout
  // ********
  always #2 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Ticks every 4 and 16 cycles; random or fixed speed.
  always @(posedge core_clk)
  begin
    tdiv       <= tdiv + 4'h1;
    cycle_tick <= (tdiv[1:0] == 2'h3);
    ms_tick    <= (tdiv == 4'hf);
    rnd_q      <= lfsr(rnd_q);
    speed_in   <= rnd_en ? {8'h00, rnd_q[7:0]} : spd_fix;
    cyc        <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One access, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // Ask the controller for a stop of either kind, len plus one cycles long.
  task automatic cmd(input logic two, input logic [15:0] len);
    @(posedge core_clk);
    go_one <= ~two;
    go_two <= two;
    go_len <= len;
    @(posedge core_clk);
    go_one <= 1'b0;
    go_two <= 1'b0;
  endtask : cmd

  // Counts stop ticks to the end; nb is the count at braking.
  task automatic watch(output int nt, output int nb);
    int k;
    nt = 0;
    nb = -1;
    k = 0;
    @(negedge core_clk);
    while (torque_off !== 1'b1 && hold_active !== 1'b1 && k < 5000)
    begin
      if (brake_cmd === 1'b1 && nb < 0)
        nb = nt;
      if ((stop_one_active === 1'b1 || stop_two_active === 1'b1) && cycle_tick === 1'b1)
        nt++;
      k++;
      @(negedge core_clk);
    end
  endtask : watch

  // Waits, bounded, until torque off, hold and both stop triggers are low again.
  task automatic settle();
    int k;
    k = 0;
    @(negedge core_clk);
    while ((torque_off | hold_active | stop_one_trig | stop_two_trig) !== 1'b0 && k < 5000)
    begin
      k++;
      @(negedge core_clk);
    end
  endtask : settle

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // ********
  // Test sequence
  // ********
  initial
  begin
    int          nt, nb;
    logic [31:0] q;
    {core_clk, rstn, avs_read, avs_write, go_one, go_two, go_ack} = 7'h00;
    {avs_address, avs_writedata, tdiv, cyc, error_cnt, compares} = 0;
    {cycle_tick, ms_tick, speed_in, spd_fix, go_len} = 0;
    avs_byteenable = 4'hf;
    rnd_q = 32'd78660;
    rnd_en = 1'b1;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    // Reset values, unmapped read, write back.
    bus(1'b0, `SSS_OFS_TOFF, 32'h0, q);
    check(q, 32'h64);
    bus(1'b0, `SSS_OFS_HOLD, 32'h0, q);
    check(q, 32'h64);
    bus(1'b0, 8'h30, 32'h0, q);
    check(q, 32'h0);
    wr(`SSS_OFS_TOFF, 32'h5);
    bus(1'b0, `SSS_OFS_TOFF, 32'h0, q);
    check(q, 32'h5);
    $display("test registers done");
    // Short trigger: torque off after five ticks.
    cmd(1'b0, 16'h0001);
    watch(nt, nb);
    check(nt, 5);
    check(nb, 32'hffffffff);
    settle();
    check(torque_off, 1'b0);
    $display("test delay done");
    // Manual restart waits for acknowledge.
    wr(`SSS_OFS_CTRL, 32'h2);
    cmd(1'b0, 16'd60);
    watch(nt, nb);
    check(nt, 5);
    while (stop_one_trig !== 1'b0)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    check(torque_off, 1'b1);
    check(ack_request, 1'b1);
    go_ack <= 1'b1;
    @(posedge core_clk);
    go_ack <= 1'b0;
    settle();
    check(ack_request, 1'b0);
    wr(`SSS_OFS_CTRL, 32'h0);
    $display("test manual done");
    // Dwell end with brake one: torque two ticks after brake.
    wr(`SSS_OFS_BSEL, 32'h1);
    wr(`SSS_OFS_BTIME, 32'h2);
    wr(`SSS_OFS_TOFF, 32'd20);
    wr(`SSS_OFS_ZLIM, 32'd300);
    wr(`SSS_OFS_ZDWELL, 32'h3);
    cmd(1'b0, 16'h0001);
    watch(nt, nb);
    check(nt, nb + 2);
    check(nt < 20, 1'b1);
    settle();
    // Brake at delay minus closing time.
    wr(`SSS_OFS_ZDWELL, 32'h0);
    wr(`SSS_OFS_ZLIM, 32'h0);
    wr(`SSS_OFS_TOFF, 32'h6);
    cmd(1'b0, 16'h0001);
    watch(nt, nb);
    check(nt, 6);
    check(nb, 4);
    settle();
    wr(`SSS_OFS_BSEL, 32'h0);
    $display("test brake done");
    // Speed outside window at delay end.
    rnd_en = 1'b0;
    spd_fix = 16'd100;
    wr(`SSS_OFS_ZLIM, 32'd10);
    wr(`SSS_OFS_TOFF, 32'h5);
    cmd(1'b0, 16'h0001);
    watch(nt, nb);
    check(nt, 5);
    bus(1'b0, `SSS_OFS_STAT, 32'h0, q);
    check(q[4], 1'b1);
    settle();
    // Speed above the ramp: early error stop.
    wr(`SSS_OFS_ZLIM, 32'h0);
    wr(`SSS_OFS_CTRL, 32'h1);
    wr(`SSS_OFS_DDELAY, 32'h1);
    wr(`SSS_OFS_DSTEP, 32'h1);
    wr(`SSS_OFS_TOFF, 32'd50);
    spd_fix = 16'd50;
    cmd(1'b0, 16'h0001);
    spd_fix = 16'd300;
    watch(nt, nb);
    check(nt < 50, 1'b1);
    bus(1'b0, `SSS_OFS_STAT, 32'h0, q);
    check(q[5], 1'b1);
    settle();
    wr(`SSS_OFS_CTRL, 32'h0);
    $display("test errors done");
    // Brief stop two trigger: hold after three ticks.
    wr(`SSS_OFS_HOLD, 32'h3);
    cmd(1'b1, 16'h0001);
    watch(nt, nb);
    check(nt, 3);
    check(torque_off, 1'b0);
    settle();
    check(hold_active, 1'b0);
    $display("test stop two done");
    report_and_stop();
  end
endmodule : test_safe_stop_sequencer

bind sss_top sss_checker #(.NUM_BRAKES(NUM_BRAKES)) i_chk (.*);
